/* File: core/alarm_relay_params.svh */
// constants for the pressure alarm relay logic
`ifndef ALARM_RELAY_PARAMS_SVH
`define ALARM_RELAY_PARAMS_SVH
`define NUM_ALARMS 4
`define NUM_STD_ALARMS 2
`define NUM_CHANNELS 4
`define PRESS_W 32
`define CHAN_W 2
`define RST_TRIP_POINT 32'h0000_03e8
`define RST_CHAN 2'h0
`define RST_UNTRIP_ACT 1'b1
`define RST_LATCH_EN 1'b0
`define BELOW_RANGE_NS 100000
`define CLK_PERIOD_NS 5
`define BELOW_RANGE_CYC ((`BELOW_RANGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERR_CODE_E0 8'he0
`endif

/* File: core/alarm_relay_pkg.sv */
// types for the pressure alarm relay logic
package alarm_relay_pkg;
   typedef struct packed {
      logic enable;
      logic untrip_act;
      logic latch_en;
      logic [1:0] chan;
      logic [31:0] trip;
   } alarm_cfg_t;
   typedef struct packed {
      logic valid;
      logic connected;
      logic off_or_failed;
      logic [31:0] press;
   } chan_rd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TRIP = 2'b01,
      ST_LATCH = 2'b10
   } relay_st_t;
endpackage : alarm_relay_pkg

/* File: core/pressure_alarm_relay_logic.sv */
// per-alarm trip point, relay, latch, indicator and tone logic
`timescale 1ns/100ps
`include "alarm_relay_params.svh"
module pressure_alarm_relay_logic (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // configuration
   input wire logic aux_board_i,
   input wire logic tone_enable_i,
   input wire logic cfg_we_i,
   input wire logic [1:0] cfg_sel_i,
   input wire alarm_relay_pkg::alarm_cfg_t cfg_i,
   // channel readings
   input wire alarm_relay_pkg::chan_rd_t chan_i [`NUM_CHANNELS],
   // controls
   input wire logic latch_n_i,
   input wire logic unlatch_cmd_i,
   input wire logic silence_i,
   // outputs
   output logic [`NUM_ALARMS-1:0] relay_o,
   output logic [`NUM_ALARMS-1:0] alarm_ind_o,
   output logic [`NUM_ALARMS-1:0] latch_ind_o,
   output logic [`NUM_ALARMS-1:0] untrip_letter_a_o,
   output logic tone_o,
   output logic below_range_o,
   output logic [`NUM_CHANNELS-1:0] no_sensor_o,
   output logic [`NUM_CHANNELS-1:0] show_e0_o,
   output logic [7:0] err_code_o
);
   alarm_relay_pkg::alarm_cfg_t cfg_ff [`NUM_ALARMS];
   alarm_relay_pkg::alarm_cfg_t nxt_cfg [`NUM_ALARMS];
   alarm_relay_pkg::relay_st_t st_ff [`NUM_ALARMS];
   alarm_relay_pkg::relay_st_t nxt_st [`NUM_ALARMS];
   logic [`NUM_ALARMS-1:0] cond_ff, nxt_cond;
   logic [`NUM_ALARMS-1:0] nxt_relay, nxt_latch_ind, nxt_letter;
   logic latch_m_ff, latch_s_ff, unl_m_ff, unl_s_ff, sil_m_ff, sil_s_ff;
   logic tone_ff, nxt_tone;
   logic [`NUM_CHANNELS-1:0] conn_ff, nxt_conn;
   logic [`NUM_CHANNELS-1:0] lost;
   logic [16:0] br_cnt_ff, nxt_br_cnt;
   logic [`NUM_ALARMS-1:0] present;
   logic [`NUM_ALARMS-1:0] rise;

   // two-flop synchronisers for the pin inputs; latch reads high when open
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         latch_m_ff <= 1'b1;
         latch_s_ff <= 1'b1;
         unl_m_ff <= 1'b0;
         unl_s_ff <= 1'b0;
         sil_m_ff <= 1'b0;
         sil_s_ff <= 1'b0;
      end else begin
         latch_m_ff <= latch_n_i;
         latch_s_ff <= latch_m_ff;
         unl_m_ff <= unlatch_cmd_i;
         unl_s_ff <= unl_m_ff;
         sil_m_ff <= silence_i;
         sil_s_ff <= sil_m_ff;
      end
   end

   // per-alarm configuration, condition and relay state
   always_comb begin
      for (int i = 0; i < `NUM_ALARMS; i++) begin
         present[i] = (i < `NUM_STD_ALARMS) || aux_board_i;
         nxt_cfg[i] = cfg_ff[i];
         if (cfg_we_i && (cfg_sel_i == i[1:0])) begin
            nxt_cfg[i] = cfg_i;
         end
         nxt_cond[i] = cond_ff[i];
         nxt_st[i] = st_ff[i];
         rise[i] = 1'b0;
         if (!present[i] || !cfg_ff[i].enable) begin
            nxt_cond[i] = 1'b0;
            nxt_st[i] = alarm_relay_pkg::ST_IDLE;
         end else if (chan_i[cfg_ff[i].chan].valid && chan_i[cfg_ff[i].chan].connected
                      && !chan_i[cfg_ff[i].chan].off_or_failed) begin
            // strictly above trip; equal is no alarm
            nxt_cond[i] = chan_i[cfg_ff[i].chan].press > cfg_ff[i].trip;
            rise[i] = nxt_cond[i] && !cond_ff[i];
            unique case (st_ff[i])
               alarm_relay_pkg::ST_IDLE: begin
                  if (nxt_cond[i]) begin
                     nxt_st[i] = alarm_relay_pkg::ST_TRIP;
                  end
               end
               alarm_relay_pkg::ST_TRIP: begin
                  if (!nxt_cond[i]) begin
                     if (cfg_ff[i].latch_en && !latch_s_ff) begin
                        nxt_st[i] = alarm_relay_pkg::ST_LATCH;
                     end else begin
                        nxt_st[i] = alarm_relay_pkg::ST_IDLE;
                     end
                  end
               end
               alarm_relay_pkg::ST_LATCH: begin
                  if (nxt_cond[i]) begin
                     nxt_st[i] = alarm_relay_pkg::ST_TRIP;
                  end else if (latch_s_ff || unl_s_ff) begin
                     nxt_st[i] = alarm_relay_pkg::ST_IDLE;
                  end
               end
               default: nxt_st[i] = alarm_relay_pkg::ST_IDLE;
            endcase
         end else if (!chan_i[cfg_ff[i].chan].connected
                      || chan_i[cfg_ff[i].chan].off_or_failed) begin
            // source lost: idle unless tripped or latched
            nxt_cond[i] = cond_ff[i];
         end
         nxt_relay[i] = (nxt_st[i] == alarm_relay_pkg::ST_IDLE) ?
                        (cfg_ff[i].untrip_act && present[i] && cfg_ff[i].enable &&
                         chan_i[cfg_ff[i].chan].connected &&
                         !chan_i[cfg_ff[i].chan].off_or_failed) :
                        !cfg_ff[i].untrip_act;
         nxt_latch_ind[i] = cfg_ff[i].latch_en && (nxt_st[i] != alarm_relay_pkg::ST_IDLE)
                            && !latch_s_ff;
         nxt_letter[i] = nxt_cfg[i].untrip_act;
      end
   end

   // tone, sensor presence and below-range pulse
   always_comb begin
      nxt_conn = conn_ff;
      lost = '0;
      for (int c = 0; c < `NUM_CHANNELS; c++) begin
         nxt_conn[c] = chan_i[c].connected;
         lost[c] = conn_ff[c] && !chan_i[c].connected;
      end
      nxt_tone = tone_ff;
      if (sil_s_ff) begin
         nxt_tone = 1'b0;
      end
      if ((|rise) || (|lost)) begin
         nxt_tone = 1'b1;
      end
      if (!tone_enable_i) begin
         nxt_tone = 1'b0;
      end
      nxt_br_cnt = (br_cnt_ff != 17'h0) ? br_cnt_ff - 17'h1 : 17'h0;
      if (|lost) begin
         nxt_br_cnt = 17'(`BELOW_RANGE_CYC);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int i = 0; i < `NUM_ALARMS; i++) begin
            cfg_ff[i].enable <= 1'b1;
            cfg_ff[i].untrip_act <= `RST_UNTRIP_ACT;
            cfg_ff[i].latch_en <= `RST_LATCH_EN;
            cfg_ff[i].chan <= `RST_CHAN;
            cfg_ff[i].trip <= `RST_TRIP_POINT;
            st_ff[i] <= alarm_relay_pkg::ST_IDLE;
         end
         cond_ff <= '0;
         relay_o <= '0;
         alarm_ind_o <= '0;
         latch_ind_o <= '0;
         untrip_letter_a_o <= '1;
         tone_ff <= 1'b0;
         conn_ff <= '1;
         br_cnt_ff <= 17'h0;
         below_range_o <= 1'b0;
         no_sensor_o <= '0;
         show_e0_o <= '0;
         err_code_o <= `ERR_CODE_E0;
      end else begin
         for (int i = 0; i < `NUM_ALARMS; i++) begin
            cfg_ff[i] <= nxt_cfg[i];
            st_ff[i] <= nxt_st[i];
         end
         cond_ff <= nxt_cond;
         relay_o <= nxt_relay;
         alarm_ind_o <= nxt_cond;
         latch_ind_o <= nxt_latch_ind;
         untrip_letter_a_o <= nxt_letter;
         tone_ff <= nxt_tone;
         conn_ff <= nxt_conn;
         br_cnt_ff <= nxt_br_cnt;
         below_range_o <= (nxt_br_cnt != 17'h0);
         no_sensor_o <= ~nxt_conn;
         show_e0_o <= ~nxt_conn;
         err_code_o <= `ERR_CODE_E0;
      end
   end

   assign tone_o = tone_ff;

   // checks
   AST_IND_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      alarm_ind_o == cond_ff)
      else $error("indicator differs from condition");
   AST_NO_LATCH_IND: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(!cfg_ff[0].latch_en) |-> !latch_ind_o[0])
      else $error("latch shown while off");
   AST_TONE_GATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(!tone_enable_i) |-> !tone_o)
      else $error("tone while disabled");
   AST_AUX_ABSENT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(!aux_board_i) |-> alarm_ind_o[3:2] == 2'b00)
      else $error("aux alarm active");
   AST_RISE_TONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (tone_enable_i && |rise) |=> tone_o)
      else $error("no tone on alarm");
   AST_DISABLED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!cfg_ff[0].enable ##1 !cfg_ff[0].enable) |-> !relay_o[0] && !alarm_ind_o[0])
      else $error("disabled alarm active");
   AST_LOST_BR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      |lost |=> below_range_o ##1 below_range_o)
      else $error("no below range");
   AST_E0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      show_e0_o == no_sensor_o && no_sensor_o == ~{$past(chan_i[3].connected),
      $past(chan_i[2].connected), $past(chan_i[1].connected), $past(chan_i[0].connected)})
      else $error("e0 mismatch");

   // relay path
   AST_TRIP_FLIP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_ff[1] != alarm_relay_pkg::ST_IDLE && $stable(cfg_ff[1].untrip_act))
      |-> relay_o[1] != cfg_ff[1].untrip_act)
      else $error("tripped relay not flipped");
   AST_COND_ABOVE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(cfg_ff[0].enable && chan_i[cfg_ff[0].chan].valid
      && chan_i[cfg_ff[0].chan].connected && !chan_i[cfg_ff[0].chan].off_or_failed)
      |-> alarm_ind_o[0] == $past(chan_i[cfg_ff[0].chan].press > cfg_ff[0].trip))
      else $error("condition not strictly above trip");
   AST_LATCH_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_ff[1] == alarm_relay_pkg::ST_LATCH && cfg_ff[1].enable && !latch_s_ff && !unl_s_ff)
      |=> st_ff[1] != alarm_relay_pkg::ST_IDLE)
      else $error("latched relay let go");
   AST_RELEASE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ($past(st_ff[1] == alarm_relay_pkg::ST_LATCH && cfg_ff[1].enable)
      && st_ff[1] == alarm_relay_pkg::ST_IDLE) |-> $past(latch_s_ff || unl_s_ff) && !alarm_ind_o[1])
      else $error("latch released without cause");
   AST_NO_LATCH_OPEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (st_ff[1] == alarm_relay_pkg::ST_TRIP && latch_s_ff) |=> st_ff[1] != alarm_relay_pkg::ST_LATCH)
      else $error("latched with latch input high");
   AST_LATCH_IND_CLR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      st_ff[1] == alarm_relay_pkg::ST_IDLE |-> !latch_ind_o[1])
      else $error("latch shown on idle relay");
   AST_LETTER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(cfg_we_i && cfg_sel_i == 2'h1) |-> untrip_letter_a_o[1] == $past(cfg_i.untrip_act))
      else $error("idle state letter wrong");
   AST_RESET_DEFAULT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(rst_i) |-> cfg_ff[0].trip == `RST_TRIP_POINT && cfg_ff[0].chan == `RST_CHAN
      && cfg_ff[0].untrip_act && !cfg_ff[0].latch_en)
      else $error("reset defaults wrong");
   AST_AUX_RELAY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(!aux_board_i) |-> relay_o[3:2] == 2'b00)
      else $error("aux relay active");

   // source loss
   AST_LOSS_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cfg_ff[1].enable && !chan_i[cfg_ff[1].chan].connected) |=> $stable(st_ff[1]))
      else $error("relay state moved on lost source");
   AST_LOSS_NO_COND: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (cfg_ff[1].enable && !chan_i[cfg_ff[1].chan].connected) |=> $stable(alarm_ind_o[1]))
      else $error("sensor loss changed alarm");
   AST_LOST_IDLE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(st_ff[2] == alarm_relay_pkg::ST_IDLE && !chan_i[cfg_ff[2].chan].connected)
      |-> !relay_o[2])
      else $error("idle relay not deactuated on lost source");

   // tone
   AST_SILENCE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (sil_s_ff && !(|rise) && !(|lost)) |=> !tone_o)
      else $error("silence ignored");
   AST_LOSS_TONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (tone_enable_i && |lost) |=> tone_o)
      else $error("no tone on sensor loss");
   AST_TONE_STAYS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (tone_o && !sil_s_ff && tone_enable_i) |=> tone_o)
      else $error("tone stopped by itself");

   // length of the below-range pulse
   logic [16:0] br_len_ff;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !below_range_o || (|lost)) begin
         br_len_ff <= 17'h0;
      end else if (br_len_ff != 17'h1ffff) begin
         br_len_ff <= br_len_ff + 17'h1;
      end
   end
   AST_BR_LEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      br_len_ff <= 17'(`BELOW_RANGE_CYC))
      else $error("below range pulse too long");

   // scenarios
   COV_TRIP: cover property (@(posedge clk_sys_i) st_ff[0] == alarm_relay_pkg::ST_TRIP);
   COV_LATCH: cover property (@(posedge clk_sys_i) st_ff[0] == alarm_relay_pkg::ST_LATCH);
   COV_LOST: cover property (@(posedge clk_sys_i) |lost);
   COV_SILENCE: cover property (@(posedge clk_sys_i) sil_s_ff && tone_o);
   COV_UNLATCH: cover property (@(posedge clk_sys_i)
      st_ff[1] == alarm_relay_pkg::ST_LATCH ##1 st_ff[1] == alarm_relay_pkg::ST_IDLE);
endmodule : pressure_alarm_relay_logic

/* File: dv/chan_model.sv */
// partner model: channel readings and latch wiring
`timescale 1ns/100ps
module chan_model (
   // test controls
   input wire logic [31:0] press_i [4],
   input wire logic [3:0] conn_i,
   input wire logic latch_closed_i,
   // toward the design
   output alarm_relay_pkg::chan_rd_t chan_o [4],
   output logic latch_n_o
);
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         chan_o[k].valid = 1'b1;
         chan_o[k].off_or_failed = 1'b0;
         chan_o[k].connected = conn_i[k];
         // a lost sensor no longer shows its last reading
         chan_o[k].press = conn_i[k] ? press_i[k] : ~press_i[k];
      end
   end
   // open contact reads high, closure to ground reads low
   assign latch_n_o = ~latch_closed_i;
endmodule : chan_model

/* File: dv/tb.sv */
// self-checking bench for the alarm relay logic
`timescale 1ns/100ps
module tb;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic aux_board_i = 1'b1;
   logic tone_enable_i = 1'b1;
   logic cfg_we_i = 1'b0;
   logic [1:0] cfg_sel_i = 2'h0;
   alarm_relay_pkg::alarm_cfg_t cfg_i = '0;
   alarm_relay_pkg::chan_rd_t chan_i [4];
   logic [31:0] press [4] = '{default: 32'h0};
   logic [3:0] conn = 4'hf;
   logic latch_closed = 1'b0;
   logic latch_n_i, unlatch_cmd_i = 1'b0, silence_i = 1'b0;
   logic [3:0] relay_o, alarm_ind_o, latch_ind_o, untrip_letter_a_o, no_sensor_o, show_e0_o;
   logic tone_o, below_range_o;
   logic [7:0] err_code_o;
   int miscompares = 0, comparisons = 0, cycles = 0;
   integer seed = 32'hd35b6e0e;
   logic [31:0] trip3, p3;
   logic ua3, a3;
   chan_model model_u (.press_i(press), .conn_i(conn), .latch_closed_i(latch_closed),
      .chan_o(chan_i), .latch_n_o(latch_n_i));
   pressure_alarm_relay_logic dut_u (.clk_sys_i, .rst_i, .aux_board_i, .tone_enable_i,
      .cfg_we_i, .cfg_sel_i, .cfg_i, .chan_i, .latch_n_i, .unlatch_cmd_i, .silence_i,
      .relay_o, .alarm_ind_o, .latch_ind_o, .untrip_letter_a_o, .tone_o, .below_range_o,
      .no_sensor_o, .show_e0_o, .err_code_o);
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   task complete_run;
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         complete_run();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : step
   task wcfg(input logic [1:0] sel, input logic en, ua, le, input logic [31:0] tp, input logic [1:0] ch);
      cfg_sel_i = sel;
      cfg_i = '{en, ua, le, ch, tp};
      cfg_we_i = 1'b1;
      step(1);
      cfg_we_i = 1'b0;
   endtask : wcfg
   task quiet;
      silence_i = 1'b1;
      step(2);
      silence_i = 1'b0;
      step(3);
   endtask : quiet
   function automatic logic over(input logic [31:0] p, input logic [31:0] t);
      return p > t;
   endfunction : over
   initial begin
      step(3);
      rst_i = 1'b0;
      step(2);
      check(relay_o, 4'hf);
      check(untrip_letter_a_o, 4'hf);
      check({alarm_ind_o, tone_o, err_code_o}, {4'h0, 1'b0, 8'he0});
      press[0] = 32'h3e8;
      step(2);
      check(alarm_ind_o, 4'h0);
      press[0] = 32'h3e9;
      step(2);
      check({alarm_ind_o, relay_o, tone_o}, {4'hf, 4'h0, 1'b1});
      quiet();
      check(tone_o, 1'b0);
      press[0] = 32'h0;
      step(2);
      check({alarm_ind_o, relay_o}, {4'h0, 4'hf});
      wcfg(2'h1, 1'b1, 1'b0, 1'b1, 32'h3e8, 2'h0);
      latch_closed = 1'b1;
      step(4);
      check({relay_o[1], untrip_letter_a_o[1]}, 2'b00);
      press[0] = 32'h3e9;
      step(2);
      check({relay_o[1], tone_o}, 2'b11);
      quiet();
      press[0] = 32'h0;
      step(2);
      check({relay_o[1], latch_ind_o[1], alarm_ind_o[1]}, 3'b110);
      check(latch_ind_o[0], 1'b0);
      unlatch_cmd_i = 1'b1;
      step(2);
      unlatch_cmd_i = 1'b0;
      step(3);
      check({relay_o[1], latch_ind_o[1]}, 2'b00);
      latch_closed = 1'b0;
      wcfg(2'h0, 1'b0, 1'b1, 1'b0, 32'h3e8, 2'h0);
      press[0] = 32'hffff;
      step(2);
      check({relay_o[0], alarm_ind_o[0]}, 2'b00);
      quiet();
      press[0] = 32'h0;
      tone_enable_i = 1'b0;
      step(2);
      press[0] = 32'hffff;
      step(2);
      check(tone_o, 1'b0);
      press[0] = 32'h0;
      tone_enable_i = 1'b1;
      step(2);
      conn = 4'hb;
      step(2);
      check({relay_o, no_sensor_o, show_e0_o, tone_o}, {4'hc, 4'h4, 4'h4, 1'b1});
      check({below_range_o, err_code_o}, {1'b1, 8'he0});
      conn = 4'hf;
      step(2);
      check({no_sensor_o, show_e0_o}, 8'h00);
      conn = 4'he;
      step(2);
      check(relay_o, 4'h0);
      conn = 4'hf;
      press[0] = 32'hffff;
      step(2);
      conn = 4'he;
      step(2);
      check(relay_o, 4'h2);
      conn = 4'hf;
      press[0] = 32'h0;
      step(2);
      aux_board_i = 1'b0;
      press[0] = 32'hffff;
      step(3);
      check(alarm_ind_o, 4'h2);
      press[0] = 32'h0;
      aux_board_i = 1'b1;
      step(2);
      for (int i = 0; i < 80; i++) begin
         trip3 = $random(seed) & 32'hffff;
         ua3 = trip3[3];
         wcfg(2'h3, 1'b1, ua3, 1'b0, trip3, 2'h3);
         p3 = (i % 4 == 0) ? trip3 : $random(seed) & 32'hffff;
         press[3] = p3;
         step(2);
         a3 = over(p3, trip3);
         check({alarm_ind_o[3], relay_o[3]}, {a3, a3 ^ ua3});
      end
      complete_run();
   end
endmodule : tb
